// >>> dv/dpfs_ctrl_model.sv
// dpfs_ctrl_model: behavioural graphics controller driving select, strobe and aux pins
// assumes the bench calls its tasks; every pin moves on the falling clock edge
`timescale 1ns/1ps
module dpfs_ctrl_model #(
  parameter int unsigned QUIET_CYC = 200
) (
  // clock
  input wire logic clk,
  // controller pins
  output logic [3:0] video_select_lines,
  output logic strobe,
  output logic aux_select_low,
  output logic aux_select_high
);
  // ----------------------------------------------------------------
  // pin defaults
  // ----------------------------------------------------------------
  initial begin
    video_select_lines = 4'h0;
    strobe = 1'b1;
    aux_select_low = 1'b0;
    aux_select_high = 1'b0;
  end

  // ----------------------------------------------------------------
  // pin tasks
  // ----------------------------------------------------------------
  task automatic put_sel(input logic [3:0] v, input int hold);
    @(negedge clk);
    video_select_lines = v;
    repeat (hold) @(negedge clk);
  endtask : put_sel

  task automatic set_strobe(input logic b);
    @(negedge clk);
    strobe = b;
  endtask : set_strobe

  task automatic set_aux(input logic [1:0] v);
    @(negedge clk);
    aux_select_low = v[0];
    aux_select_high = v[1];
  endtask : set_aux

  // silence after a select write, and ahead of every programming sequence
  task automatic rest();
    repeat (QUIET_CYC + 20) @(negedge clk);
  endtask : rest

  // opening write of a programming sequence: start bit 0, line 3 low
  task automatic start_prog();
    put_sel(4'h0, 6);
  endtask : start_prog
endmodule : dpfs_ctrl_model

// >>> dv/tb_dpfs_select.sv
// tb_dpfs_select: self-checking bench of the frequency select front end
// assumes dpfs_pkg and the design files are compiled first; no software registers
`timescale 1ns/1ps
module tb_dpfs_select;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned QUIET = 200;
  localparam int unsigned SWITCH = 20;
  logic clk;
  logic rstn;
  logic [3:0] video_select_lines;
  logic strobe;
  logic aux_select_low;
  logic aux_select_high;
  logic [15:0] video_freq_q;
  logic [15:0] aux_freq_q;
  logic [3:0] video_index_q;
  logic [1:0] aux_index_q;
  logic prog_busy;
  logic table_wr_q;
  logic [3:0] idx_opt [1:3];
  int errors;
  int tests_run;
  int cycles;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  dpfs_select #(.QUIET_CYC(QUIET), .SWITCH_CYC(SWITCH)) u_dut (
    .clk(clk), .rstn(rstn), .video_select_lines(video_select_lines), .strobe(strobe),
    .aux_select_low(aux_select_low), .aux_select_high(aux_select_high),
    .video_freq_q(video_freq_q), .aux_freq_q(aux_freq_q), .video_index_q(video_index_q),
    .aux_index_q(aux_index_q), .prog_busy(prog_busy), .table_wr_q(table_wr_q)
  );
  // strobe build options: 1 rising edge, 2 falling edge, 3 transparent while low
  for (genvar m = 1; m < 4; m++) begin : g_opt
    dpfs_select #(.STB_MODE(dpfs_pkg::dpfs_stb_mode_t'(m)), .QUIET_CYC(QUIET), .SWITCH_CYC(SWITCH)) u_dut (
      .clk(clk), .rstn(rstn), .video_select_lines(video_select_lines), .strobe(strobe),
      .aux_select_low(aux_select_low), .aux_select_high(aux_select_high), .video_freq_q(), .aux_freq_q(),
      .video_index_q(idx_opt[m]), .aux_index_q(), .prog_busy(), .table_wr_q()
    );
  end
  dpfs_ctrl_model #(.QUIET_CYC(QUIET)) u_ctrl (
    .clk(clk), .video_select_lines(video_select_lines), .strobe(strobe),
    .aux_select_low(aux_select_low), .aux_select_high(aux_select_high)
  );

  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  function automatic logic [15:0] preset(input int i);
    return dpfs_pkg::DEF_BASE + dpfs_pkg::DEF_STEP * 16'(i);
  endfunction : preset

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    check("video index", 16'(video_index_q), 16'h0000);
    check("video freq", video_freq_q, preset(0));
    check("aux freq", aux_freq_q, preset(16));
    check("prog busy", 16'(prog_busy), 16'h0000);
  endtask : t_reset_vals

  // aux lines pass unlatched, even with the strobe low
  task automatic t_aux();
    for (int i = 0; i < 4; i++) begin
      if (i == 3) u_ctrl.set_strobe(1'b0);
      u_ctrl.set_aux(2'(i));
      cyc(8);
      check("aux index", 16'(aux_index_q), 16'(i));
      check("aux freq", aux_freq_q, preset(16 + i));
    end
    u_ctrl.set_strobe(1'b1);
  endtask : t_aux

  // a select write switches only after the time-out
  task automatic t_select();
    u_ctrl.put_sel(4'h5, 0);
    cyc(13);
    check("index before timeout", 16'(video_index_q), 16'h0000);
    cyc(20);
    check("index after timeout", 16'(video_index_q), 16'h0005);
    check("freq after timeout", video_freq_q, preset(5));
    check("rise index idle", 16'(idx_opt[1]), 16'h0000);
    check("fall index idle", 16'(idx_opt[2]), 16'h0000);
    check("low index idle", 16'(idx_opt[3]), 16'h0000);
    u_ctrl.rest();
  endtask : t_select

  // strobe low holds the lines, raising it passes them
  task automatic t_hold();
    u_ctrl.set_strobe(1'b0);
    u_ctrl.put_sel(4'h9, 40);
    check("index held", 16'(video_index_q), 16'h0005);
    check("rise index held", 16'(idx_opt[1]), 16'h0000);
    check("fall index taken", 16'(idx_opt[2]), 16'h0005);
    check("low index taken", 16'(idx_opt[3]), 16'h0009);
    u_ctrl.set_strobe(1'b1);
    cyc(40);
    check("index passed", 16'(video_index_q), 16'h0009);
    check("freq passed", video_freq_q, preset(9));
    check("rise index taken", 16'(idx_opt[1]), 16'h0009);
    check("fall index kept", 16'(idx_opt[2]), 16'h0005);
    check("low index kept", 16'(idx_opt[3]), 16'h0009);
    u_ctrl.rest();
  endtask : t_hold

  // programs one entry, then selects it and checks the new word
  task automatic t_prog(input logic tbl, input logic [3:0] addr, input logic [15:0] data);
    logic [20:0] frame;
    int n;
    frame = {tbl, addr, data};
    n = 0;
    u_ctrl.rest();
    u_ctrl.start_prog();
    check("busy after start", 16'(prog_busy), 16'h0001);
    for (int i = 20; i >= 0; i--) begin
      u_ctrl.put_sel({1'b0, frame[i], 2'b00}, 6);
      u_ctrl.put_sel({1'b1, frame[i], 2'b00}, (i == 0) ? 0 : 6);
    end
    while (table_wr_q !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    check("table write", 16'(table_wr_q), 16'h0001);
    cyc(2);
    check("busy after frame", 16'(prog_busy), 16'h0000);
    if (tbl) begin
      u_ctrl.set_aux(addr[1:0]);
      cyc(8);
      check("aux reprogrammed", aux_freq_q, data);
    end else begin
      u_ctrl.put_sel(addr, 40);
      check("video reprogrammed", video_freq_q, data);
    end
  endtask : t_prog

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    rstn = 1'b0;
    cyc(8);
    rstn = 1'b1;
    cyc(2);
    t_reset_vals();
    t_aux();
    t_select();
    t_hold();
    t_prog(1'b0, 4'h7, 16'hA5C3);
    t_prog(1'b1, 4'h2, 16'h3C5A);
    tally_and_finish();
  end
endmodule : tb_dpfs_select

// >>> src/dpfs_capture.sv
// dpfs_capture: synchronises select lines and strobe, latches them per strobe option
// assumes asynchronous pins; emits one pulse per write seen by the device
`timescale 1ns/1ps
module dpfs_capture #(
  parameter dpfs_pkg::dpfs_stb_mode_t STB_MODE = dpfs_pkg::STB_HIGH_TRANSP
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins
  input wire logic [3:0] sel_pin,
  input wire logic strobe_pin,
  // captured value
  output logic [3:0] sel_q,
  output logic write_pulse
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sel_m_q;
  logic [3:0] sel_s_q;
  logic stb_m_q;
  logic stb_s_q;
  logic stb_p_q;
  logic take;
  logic edge_mode;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_m_q <= 4'h0;
      sel_s_q <= 4'h0;
      // strobe idles high, so no false edge follows reset
      stb_m_q <= 1'b1;
      stb_s_q <= 1'b1;
      stb_p_q <= 1'b1;
    end else begin
      sel_m_q <= sel_pin;
      sel_s_q <= sel_m_q;
      stb_m_q <= strobe_pin;
      stb_s_q <= stb_m_q;
      stb_p_q <= stb_s_q;
    end
  end

  // ----------------------------------------------------------------
  // latch per option
  // ----------------------------------------------------------------
  assign edge_mode = (STB_MODE == dpfs_pkg::STB_RISE) || (STB_MODE == dpfs_pkg::STB_FALL);

  always_comb begin
    case (STB_MODE)
      dpfs_pkg::STB_HIGH_TRANSP: take = stb_s_q;
      dpfs_pkg::STB_RISE: take = stb_s_q && !stb_p_q;
      dpfs_pkg::STB_FALL: take = !stb_s_q && stb_p_q;
      dpfs_pkg::STB_LOW_TRANSP: take = !stb_s_q;
      default: take = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_q <= dpfs_pkg::VID_RST_IDX;
      write_pulse <= 1'b0;
    end else begin
      if (take) begin
        sel_q <= sel_s_q;
      end
      write_pulse <= take && (edge_mode || (sel_s_q != sel_q));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
    (STB_MODE == dpfs_pkg::STB_HIGH_TRANSP) && !$past(stb_s_q) |-> $stable(sel_q))
    else $error("select latch moved while strobe low");
  chk_edge_only: assert property (@(posedge clk) disable iff (!rstn)
    edge_mode && write_pulse |-> $past(stb_s_q) != $past(stb_p_q))
    else $error("edge capture without strobe edge");

endmodule : dpfs_capture

// >>> src/dpfs_pkg.sv
// dpfs_pkg: constants and types of the dual synthesizer frequency select front end
// assumes a single 40 MHz system clock; all long times are counted in that clock
package dpfs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned QUIET_MS = 50;
  localparam int unsigned QUIET_CYC = (CLK_HZ / 1000) * QUIET_MS;
  localparam int unsigned SWITCH_MS = 10;
  localparam int unsigned SWITCH_CYC = (CLK_HZ / 1000) * SWITCH_MS;
  localparam int unsigned TMR_W = 24;

  // ----------------------------------------------------------------
  // tables
  // ----------------------------------------------------------------
  localparam int unsigned VID_ENTRIES = 16;
  localparam int unsigned AUX_ENTRIES = 4;
  localparam int unsigned TBL_DEPTH = VID_ENTRIES + AUX_ENTRIES;
  localparam int unsigned TBL_AW = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0] VID_RST_IDX = 4'h0;
  localparam logic [1:0] AUX_RST_IDX = 2'h0;
  localparam logic [15:0] DEF_BASE = 16'h0100;
  localparam logic [15:0] DEF_STEP = 16'h0010;

  // ----------------------------------------------------------------
  // serial frame after the start bit: table, address, data (msb first)
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 21;
  localparam int unsigned FRM_TBL_POS = 20;
  localparam int unsigned FRM_ADDR_MSB = 19;
  localparam int unsigned FRM_ADDR_LSB = 16;
  localparam int unsigned FRM_DATA_MSB = 15;
  localparam int unsigned SEL_DATA_BIT = 2;
  localparam int unsigned SEL_SHIFT_BIT = 3;
  localparam logic [4:0] FRM_CNT_RST = 5'h00;
  localparam logic [4:0] FRM_CNT_LAST = 5'h14;

  // ----------------------------------------------------------------
  // strobe options and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {STB_HIGH_TRANSP, STB_RISE, STB_FALL, STB_LOW_TRANSP} dpfs_stb_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_PROG} dpfs_state_t;

endpackage : dpfs_pkg

// >>> src/dpfs_select.sv
// dpfs_select: frequency selection and serial table loading of a dual synthesizer
// assumes select pins from a graphics controller, asynchronous to clk;
// the synthesizers consume the frequency words driven out here
//
// Functional notes
// - video frequency word comes from the entry the four video select lines address
// - auxiliary frequency word is one of four entries chosen by two aux lines
// - controller may rewrite video and auxiliary table entries any time after power-up
// - standard option: select lines pass while strobe high, held while low
// - build options: rising edge, falling edge, or transparent while strobe low
// - select lines with strobe both choose frequency and load table data
// - video word switches to new entry after a short time-out following a write
// - entry 0 is used from power-up until the time-out following the first write
// - aux lines are decoded directly, unlatched, never used for programming
// - 50 ms without writes clears the shift register; writes then program
`timescale 1ns/1ps
module dpfs_select #(
  parameter dpfs_pkg::dpfs_stb_mode_t STB_MODE = dpfs_pkg::STB_HIGH_TRANSP,
  parameter int unsigned QUIET_CYC = dpfs_pkg::QUIET_CYC,
  parameter int unsigned SWITCH_CYC = dpfs_pkg::SWITCH_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // controller pins
  input wire logic [3:0] video_select_lines,
  input wire logic strobe,
  input wire logic aux_select_low,
  input wire logic aux_select_high,
  // synthesizer words
  output logic [dpfs_pkg::DATA_W-1:0] video_freq_q,
  output logic [dpfs_pkg::DATA_W-1:0] aux_freq_q,
  // status
  output logic [3:0] video_index_q,
  output logic [1:0] aux_index_q,
  output logic prog_busy,
  output logic table_wr_q
);

  localparam int unsigned FB = dpfs_pkg::FRAME_BITS;
  localparam int unsigned TW = dpfs_pkg::TMR_W;

  // ----------------------------------------------------------------
  // capture of the video select lines
  // ----------------------------------------------------------------
  logic [3:0] sel_q;
  logic wr_pulse;

  dpfs_capture #(
    .STB_MODE(STB_MODE)
  ) u_capture (
    .clk(clk),
    .rstn(rstn),
    .sel_pin(video_select_lines),
    .strobe_pin(strobe),
    .sel_q(sel_q),
    .write_pulse(wr_pulse)
  );

  // ----------------------------------------------------------------
  // auxiliary lines: synchronised, decoded directly
  // ----------------------------------------------------------------
  logic [1:0] aux_m_q;
  logic [1:0] aux_s_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aux_m_q <= dpfs_pkg::AUX_RST_IDX;
      aux_s_q <= dpfs_pkg::AUX_RST_IDX;
      aux_index_q <= dpfs_pkg::AUX_RST_IDX;
    end else begin
      aux_m_q <= {aux_select_high, aux_select_low};
      aux_s_q <= aux_m_q;
      aux_index_q <= aux_s_q;
    end
  end

  // ----------------------------------------------------------------
  // quiet timer
  // ----------------------------------------------------------------
  logic [TW-1:0] quiet_cnt_q;
  logic quiet_done;

  assign quiet_done = (quiet_cnt_q >= TW'(QUIET_CYC));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      quiet_cnt_q <= TW'(QUIET_CYC);
    end else if (wr_pulse) begin
      quiet_cnt_q <= '0;
    end else if (!quiet_done) begin
      quiet_cnt_q <= quiet_cnt_q + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // mode state
  // ----------------------------------------------------------------
  dpfs_pkg::dpfs_state_t state_q;
  logic start_ok;
  logic shift_pulse;
  logic frame_done;
  logic [4:0] bit_cnt_q;
  logic [FB-1:0] shreg_q;
  logic [FB-1:0] shreg_d;
  logic sel3_prev_q;

  assign start_ok = wr_pulse && quiet_done && !sel_q[dpfs_pkg::SEL_SHIFT_BIT] &&
                    !sel_q[dpfs_pkg::SEL_DATA_BIT];
  assign shift_pulse = (state_q == dpfs_pkg::ST_PROG) && wr_pulse && !sel3_prev_q &&
                       sel_q[dpfs_pkg::SEL_SHIFT_BIT];
  assign frame_done = shift_pulse && (bit_cnt_q == dpfs_pkg::FRM_CNT_LAST);
  assign shreg_d = {shreg_q[FB-2:0], sel_q[dpfs_pkg::SEL_DATA_BIT]};
  assign prog_busy = (state_q == dpfs_pkg::ST_PROG);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= dpfs_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dpfs_pkg::ST_IDLE: begin
          if (start_ok) begin
            state_q <= dpfs_pkg::ST_PROG;
          end else if (wr_pulse) begin
            state_q <= dpfs_pkg::ST_ACTIVE;
          end
        end
        dpfs_pkg::ST_ACTIVE: begin
          if (start_ok) begin
            state_q <= dpfs_pkg::ST_PROG;
          end else if (quiet_done) begin
            state_q <= dpfs_pkg::ST_IDLE;
          end
        end
        dpfs_pkg::ST_PROG: begin
          if (frame_done) begin
            state_q <= dpfs_pkg::ST_ACTIVE;
          end else if (quiet_done) begin
            state_q <= dpfs_pkg::ST_IDLE;
          end
        end
        default: state_q <= dpfs_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial shift register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel3_prev_q <= 1'b0;
    end else if (wr_pulse) begin
      sel3_prev_q <= sel_q[dpfs_pkg::SEL_SHIFT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shreg_q <= '0;
      bit_cnt_q <= dpfs_pkg::FRM_CNT_RST;
    end else if (quiet_done || start_ok || frame_done) begin
      shreg_q <= '0;
      bit_cnt_q <= dpfs_pkg::FRM_CNT_RST;
    end else if (shift_pulse) begin
      shreg_q <= shreg_d;
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // table write from a completed frame
  // ----------------------------------------------------------------
  logic [dpfs_pkg::TBL_AW-1:0] wr_addr;
  logic [3:0] frm_addr;

  assign frm_addr = shreg_d[dpfs_pkg::FRM_ADDR_MSB:dpfs_pkg::FRM_ADDR_LSB];
  assign wr_addr = shreg_d[dpfs_pkg::FRM_TBL_POS] ?
                   5'(dpfs_pkg::VID_ENTRIES) + {3'h0, frm_addr[1:0]} : {1'b0, frm_addr};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      table_wr_q <= 1'b0;
    end else begin
      table_wr_q <= frame_done;
    end
  end

  // ----------------------------------------------------------------
  // switch time-out and active entry
  // ----------------------------------------------------------------
  logic [TW-1:0] sw_cnt_q;
  logic sw_pend_q;
  logic sw_fire;

  assign sw_fire = sw_pend_q && (sw_cnt_q >= TW'(SWITCH_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sw_pend_q <= 1'b0;
      sw_cnt_q <= '0;
    end else if (wr_pulse) begin
      sw_pend_q <= (state_q != dpfs_pkg::ST_PROG);
      sw_cnt_q <= '0;
    end else if (sw_fire) begin
      sw_pend_q <= 1'b0;
    end else if (sw_pend_q) begin
      sw_cnt_q <= sw_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      video_index_q <= dpfs_pkg::VID_RST_IDX;
    end else if (sw_fire) begin
      video_index_q <= sel_q;
    end
  end

  // ----------------------------------------------------------------
  // frequency table
  // ----------------------------------------------------------------
  dpfs_table u_table (
    .clk(clk),
    .rstn(rstn),
    .wr_en(frame_done),
    .wr_addr(wr_addr),
    .wr_data(shreg_d[dpfs_pkg::FRM_DATA_MSB:0]),
    .rd_a_addr({1'b0, video_index_q}),
    .rd_a_q(video_freq_q),
    .rd_b_addr(5'(dpfs_pkg::VID_ENTRIES) + {3'h0, aux_index_q}),
    .rd_b_q(aux_freq_q)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic switched_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      switched_q <= 1'b0;
    end else if (sw_fire) begin
      switched_q <= 1'b1;
    end
  end

  chk_power_entry: assert property (@(posedge clk) disable iff (!rstn)
    !switched_q |-> video_index_q == dpfs_pkg::VID_RST_IDX)
    else $error("entry other than 0 before first switch");
  chk_switch_cause: assert property (@(posedge clk) disable iff (!rstn)
    $changed(video_index_q) |-> $past(sw_fire))
    else $error("video entry changed without time-out");
  chk_switch_wait: assert property (@(posedge clk) disable iff (!rstn)
    sw_fire |-> sw_cnt_q == TW'(SWITCH_CYC - 1))
    else $error("switch fired before time-out");
  chk_aux_direct: assert property (@(posedge clk) disable iff (!rstn)
    ##2 aux_index_q == $past({aux_select_high, aux_select_low}, 3))
    else $error("aux index not a direct decode of aux lines");
  chk_aux_read: assert property (@(posedge clk) disable iff (!rstn)
    $stable(aux_index_q) && !table_wr_q ##1 $stable(aux_index_q) |-> $stable(aux_freq_q))
    else $error("aux word moved with stable aux select");
  chk_quiet_clear: assert property (@(posedge clk) disable iff (!rstn)
    quiet_done |=> bit_cnt_q == dpfs_pkg::FRM_CNT_RST && shreg_q == '0)
    else $error("shift register not cleared after quiet period");
  chk_prog_entry: assert property (@(posedge clk) disable iff (!rstn)
    state_q != dpfs_pkg::ST_PROG ##1 state_q == dpfs_pkg::ST_PROG |->
      $past(quiet_done) && $past(sel_q[3:2]) == 2'h0)
    else $error("programming entered without quiet and start bit");
  chk_shift_edge: assert property (@(posedge clk) disable iff (!rstn)
    shift_pulse && !frame_done && !quiet_done |=>
      bit_cnt_q == $past(bit_cnt_q) + 5'h01 && shreg_q[0] == $past(sel_q[2]))
    else $error("shift on line 3 rise not taken");
  chk_no_shift: assert property (@(posedge clk) disable iff (!rstn)
    !shift_pulse && !quiet_done && !start_ok && !frame_done |=> $stable(bit_cnt_q))
    else $error("bit counter moved without shift edge");
  chk_prog_hold: assert property (@(posedge clk) disable iff (!rstn)
    wr_pulse && prog_busy |=> !sw_pend_q)
    else $error("programming write scheduled a frequency switch");
  chk_video_read: assert property (@(posedge clk) disable iff (!rstn)
    $stable(video_index_q) && !table_wr_q ##1 $stable(video_index_q) |-> $stable(video_freq_q))
    else $error("video word moved with stable video entry");
  chk_quiet_restart: assert property (@(posedge clk) disable iff (!rstn)
    wr_pulse |=> !quiet_done)
    else $error("quiet period not restarted by a write");
  chk_prog_abort: assert property (@(posedge clk) disable iff (!rstn)
    prog_busy && quiet_done |=> !prog_busy)
    else $error("programming not aborted after quiet period");
  chk_start_clear: assert property (@(posedge clk) disable iff (!rstn)
    start_ok && !prog_busy |=> prog_busy && bit_cnt_q == dpfs_pkg::FRM_CNT_RST)
    else $error("start write did not open a clean frame");
  chk_frame_write: assert property (@(posedge clk) disable iff (!rstn)
    frame_done |=> table_wr_q && !prog_busy)
    else $error("completed frame not written to table");

  cov_switch: cover property (@(posedge clk) disable iff (!rstn) sw_fire && sel_q != video_index_q);
  cov_frame: cover property (@(posedge clk) disable iff (!rstn) frame_done);
  cov_prog_abort: cover property (@(posedge clk) disable iff (!rstn) prog_busy && quiet_done);
  cov_prog_start: cover property (@(posedge clk) disable iff (!rstn) start_ok && !prog_busy);
  cov_aux_change: cover property (@(posedge clk) disable iff (!rstn) $changed(aux_index_q));

endmodule : dpfs_select

// >>> src/dpfs_table.sv
// dpfs_table: frequency table memory, video entries then auxiliary entries
// assumes one write port from the serial loader; reads are registered
`timescale 1ns/1ps
module dpfs_table #(
  parameter int unsigned DEPTH = dpfs_pkg::TBL_DEPTH,
  parameter int unsigned AW = dpfs_pkg::TBL_AW,
  parameter int unsigned DW = dpfs_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read ports
  input wire logic [AW-1:0] rd_a_addr,
  output logic [DW-1:0] rd_a_q,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [DW-1:0] rd_b_q
);

  logic [DW-1:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // entries, preset values at reset
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    localparam logic [DW-1:0] PRESET = DW'(dpfs_pkg::DEF_BASE + dpfs_pkg::DEF_STEP * i);
    always_ff @(posedge clk) begin
      if (!rstn) begin
        mem_q[i] <= PRESET;
      end else if (wr_en && (wr_addr == AW'(i))) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_a_q <= DW'(dpfs_pkg::DEF_BASE);
      rd_b_q <= DW'(dpfs_pkg::DEF_BASE + dpfs_pkg::DEF_STEP * dpfs_pkg::VID_ENTRIES);
    end else begin
      rd_a_q <= mem_q[rd_a_addr];
      rd_b_q <= mem_q[rd_b_addr];
    end
  end

  chk_read_path: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> rd_a_q == $past(mem_q[rd_a_addr]))
    else $error("video read data not from addressed entry");

endmodule : dpfs_table
